/* actuator_model.sv */
// passive model of the remote valve actuator fed by the command link
// assumes cmd and cmd_send are registered on aclk by the thermostat
`timescale 1ns/1ns
module actuator_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // command link
  input wire logic cmd,
  input wire logic cmd_send,
  // observed state
  output logic valve,
  output int n_rx,
  output int n_bad
);
  // ----------------------------------------------------------------
  // telegram reception
  // ----------------------------------------------------------------
  // a telegram repeating the held state wastes a frame; a change
  // without a telegram leaves the valve stale, so both count as bad
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      valve <= 1'h0;
      n_rx <= 0;
      n_bad <= 0;
    end else if (cmd_send) begin
      valve <= cmd;
      n_rx <= n_rx + 1;
      if (cmd === valve) begin
        n_bad <= n_bad + 1;
      end
    end else if (cmd !== valve) begin
      n_bad <= n_bad + 1;
    end
  end
endmodule : actuator_model

/* hyst_decide.sv */
// two-point decision with hysteresis for one season
// assumes signed temperatures; all inputs on the caller's clock
`timescale 1ns/1ns
module hyst_decide #(
  parameter int W = 16
) (
  // operands
  input wire logic signed [W-1:0] temp,
  input wire logic signed [W-1:0] setpt,
  input wire logic [W-1:0] band,
  // configuration
  input wire logic cool,
  input wire logic alt,
  // present and next command
  input wire logic cur,
  output logic nxt
);

  // one extra bit so setpoint plus band cannot wrap
  logic signed [W:0] t;
  logic signed [W:0] on_th;
  logic signed [W:0] off_th;
  logic turn_on;
  logic turn_off;

  // thresholds per season and placement
  always_comb begin
    t = {temp[W-1], temp};
    on_th = {setpt[W-1], setpt};
    off_th = {setpt[W-1], setpt};
    if (!cool && !alt) begin
      on_th = {setpt[W-1], setpt} - {1'b0, band};
    end else if (!cool && alt) begin
      off_th = {setpt[W-1], setpt} + {1'b0, band};
    end else if (cool && !alt) begin
      on_th = {setpt[W-1], setpt} + {1'b0, band};
    end else begin
      off_th = {setpt[W-1], setpt} - {1'b0, band};
    end
    // default cooling turns off strictly below, alternate cooling at the threshold
    turn_on = cool ? (t > on_th) : (t < on_th);
    turn_off = cool ? (alt ? (t <= off_th) : (t < off_th)) : (t >= off_th);
    // between the thresholds the command is held
    nxt = cur ? !turn_off : turn_on;
  end

endmodule : hyst_decide

/* tb_top.sv */
// self-checking bench for the thermostat decision logic
// assumes thermo_pkg, hyst_decide and thermo_ctrl are compiled first
`timescale 1ns/1ns
module tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, cmd, cmd_send, pwm_running, valve;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rdv;
  logic prev;
  int n_fail = 0, n_checks = 0, n_rx, n_bad, exp_rx, k;
  typedef struct packed {logic wide; logic [15:0] temp; logic [6:0] ctrl; logic exp;} row_s;
  // band choice, temperature, control word, expected command
  row_s rows [24] = '{
    '{1'h0, 16'h00CE, 7'h01, 1'h0},
    '{1'h0, 16'h00CC, 7'h01, 1'h1},
    '{1'h0, 16'h00D1, 7'h01, 1'h1},
    '{1'h0, 16'h00D2, 7'h01, 1'h0},
    '{1'h0, 16'h00CD, 7'h01, 1'h0},
    '{1'h0, 16'h0109, 7'h05, 1'h0},
    '{1'h0, 16'h010A, 7'h05, 1'h1},
    '{1'h0, 16'h0104, 7'h05, 1'h1},
    '{1'h0, 16'h0103, 7'h05, 1'h0},
    '{1'h0, 16'h00D1, 7'h49, 1'h1},
    '{1'h0, 16'h00D6, 7'h49, 1'h1},
    '{1'h0, 16'h00D7, 7'h49, 1'h0},
    '{1'h0, 16'h0105, 7'h4D, 1'h1},
    '{1'h0, 16'h0100, 7'h4D, 1'h1},
    '{1'h0, 16'h00FF, 7'h4D, 1'h0},
    '{1'h0, 16'h00CF, 7'h09, 1'h0},
    '{1'h0, 16'h00CC, 7'h09, 1'h1},
    '{1'h1, 16'h00CC, 7'h01, 1'h1},
    '{1'h1, 16'h00D2, 7'h01, 1'h0},
    '{1'h1, 16'h00CF, 7'h01, 1'h0},
    '{1'h1, 16'h00CE, 7'h01, 1'h1},
    '{1'h1, 16'h010C, 7'h05, 1'h0},
    '{1'h1, 16'h010D, 7'h05, 1'h1},
    '{1'h1, 16'h010D, 7'h00, 1'h0}};
  logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h20, 8'h30};
  logic [31:0] rv [8] = '{32'h0, 32'hC8, 32'h0005_0005, 32'h0, 32'h1000, 32'h0, 32'hD2, 32'h104};

  // ----------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------
  thermo_ctrl dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .cmd(cmd), .cmd_send(cmd_send), .pwm_running(pwm_running));
  actuator_model act (.aclk(aclk), .aresetn(aresetn), .cmd(cmd), .cmd_send(cmd_send),
    .valve(valve), .n_rx(n_rx), .n_bad(n_bad));

  // free-running 125 MHz clock
  initial begin
    forever #4 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // handshakes sampled mid-cycle: inputs only move at rising edges,
  // so the negedge view equals what the next edge will see
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha, hw, hb;
    hb = 1'h0;
    awvalid <= 1'h1;
    awaddr <= a;
    wvalid <= 1'h1;
    wdata <= d;
    bready <= 1'h1;
    while (!hb) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'h0;
      if (hw) wvalid <= 1'h0;
    end
    bready <= 1'h0;
    @(posedge aclk); // spacing so a following call never reassigns in the same step
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    hr = 1'h0;
    arvalid <= 1'h1;
    araddr <= a;
    rready <= 1'h1;
    while (!hr) begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'h0;
    end
    rready <= 1'h0;
    @(posedge aclk);
  endtask : bus_rd

  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(negedge aclk);
    chk(32'({cmd, pwm_running}), 32'h0);
    @(posedge aclk);
    foreach (ra[i]) begin
      bus_rd(ra[i], rdv, resp);
      chk(rdv, rv[i]);
    end
    // band, then temperature, then control: no stray change in between
    prev = 1'h0;
    exp_rx = 0;
    foreach (rows[i]) begin
      bus_wr(thermo_pkg::OFS_BAND, rows[i].wide ? 32'h0008_0003 : 32'h0005_0005, resp);
      bus_wr(thermo_pkg::OFS_TEMP, {16'h0, rows[i].temp}, resp);
      bus_wr(thermo_pkg::OFS_CTRL, {25'h0, rows[i].ctrl}, resp);
      @(negedge aclk);
      chk(32'(cmd), 32'(rows[i].exp));
      if (rows[i].exp !== prev) exp_rx++;
      prev = rows[i].exp;
      @(posedge aclk);
      // status shows the command and whether the swapped placement is in effect
      bus_rd(thermo_pkg::OFS_STATUS, rdv, resp);
      chk(rdv, {29'h0, rows[i].ctrl[thermo_pkg::CTRL_ALT] && rows[i].ctrl[thermo_pkg::CTRL_RADIANT], 1'h0, rows[i].exp});
    end
    bus_rd(thermo_pkg::OFS_SENDS, rdv, resp);
    chk(rdv, 32'(exp_rx));
    chk(32'(n_rx), 32'(exp_rx));
    chk(32'(n_bad), 32'h0);
    // unmapped read and read-only write are refused
    bus_rd(8'h1C, rdv, resp);
    chk(32'({rdv, resp}), 32'(thermo_pkg::RESP_SLVERR));
    bus_rd(8'h40, rdv, resp);
    chk(32'(resp), 32'(thermo_pkg::RESP_SLVERR));
    bus_wr(thermo_pkg::OFS_STATUS, 32'hFFFF_FFFF, resp);
    chk(32'(resp), 32'(thermo_pkg::RESP_SLVERR));
    // per-mode setpoint: economy slot raised, comfort slot unchanged
    bus_wr(thermo_pkg::OFS_SETPT + 8'h08, 32'hE6, resp);
    bus_wr(thermo_pkg::OFS_TEMP, 32'hE0, resp);
    bus_wr(thermo_pkg::OFS_CTRL, 32'h21, resp);
    @(negedge aclk);
    chk(32'(cmd), 32'h1);
    @(posedge aclk);
    bus_wr(thermo_pkg::OFS_CTRL, 32'h01, resp);
    @(negedge aclk);
    chk(32'(cmd), 32'h0);
    @(posedge aclk);
    bus_rd(thermo_pkg::OFS_SETPT + 8'h08, rdv, resp);
    chk(rdv, 32'hE6);
    // pwm: 16-cycle period, half duty, counted over two periods
    bus_wr(thermo_pkg::OFS_PERIOD, 32'h10, resp);
    bus_wr(thermo_pkg::OFS_CVAR, 32'h80, resp);
    bus_wr(thermo_pkg::OFS_CTRL, 32'h03, resp);
    repeat (4) @(posedge aclk);
    k = 0;
    repeat (32) begin
      @(negedge aclk);
      k += (cmd === 1'h1) ? 1 : 0;
    end
    chk(32'(k), 32'h10);
    chk(32'(pwm_running), 32'h1);
    // setpoint write early in the off phase must restart the on phase
    while (cmd !== 1'h1) @(negedge aclk);
    while (cmd !== 1'h0) @(negedge aclk);
    @(posedge aclk);
    bus_wr(thermo_pkg::OFS_SETPT, 32'hDC, resp);
    @(negedge aclk);
    chk(32'(cmd), 32'h1);
    // partial write: only the low lane of the heating band moves
    @(posedge aclk);
    wstrb <= 4'h1;
    bus_wr(thermo_pkg::OFS_BAND, 32'hFFFF_FF07, resp);
    wstrb <= 4'hF;
    bus_rd(thermo_pkg::OFS_BAND, rdv, resp);
    chk(rdv, 32'h0008_0007);
    // reset in mid-run
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(negedge aclk);
    chk(32'({cmd, pwm_running, cmd_send}), 32'h0);
    @(posedge aclk);
    bus_rd(thermo_pkg::OFS_CTRL, rdv, resp);
    chk(rdv, 32'h0);
    conclude();
  end

  // watchdog well beyond the several hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    conclude();
  end
endmodule : tb_top

/* thermo_ctrl.sv */
// room thermostat decision logic with an AXI4-Lite register file
// assumes one clock, synchronous active-low reset, a single-issue bus master
`timescale 1ns/1ns
module thermo_ctrl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [thermo_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [thermo_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // command towards the actuator link
  output logic cmd,
  output logic cmd_send,
  output logic pwm_running
);

  localparam int TW = thermo_pkg::TEMP_W;
  // setpoint words end here; words above are refused rather than aliased onto slot 0
  localparam int SETPT_END = int'(thermo_pkg::OFS_SETPT) + 4 * thermo_pkg::SETPT_N;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic aw_got;
    logic [thermo_pkg::ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [thermo_pkg::CTRL_W-1:0] ctrl;
    logic [TW-1:0] temp;
    logic [TW-1:0] hband;
    logic [TW-1:0] cband;
    logic [thermo_pkg::CVAR_W-1:0] cvar;
    logic [31:0] period;
    logic [thermo_pkg::SETPT_N-1:0][TW-1:0] setpt;
    logic [2:0] act_idx;
    logic running;
    logic [31:0] cnt;
    logic [31:0] on_len;
    logic cmd;
    logic send;
    logic [15:0] sends;
  } state_s;

  state_s s;
  state_s next_s;

  logic en;
  logic pwm;
  logic cool;
  logic alt_eff;
  logic [2:0] idx;
  logic [TW-1:0] sp;
  logic hyst_nxt;
  logic wr_fire;
  logic sp_chg;
  logic wrap;
  logic [31:0] merged;
  logic [39:0] prod;

  // byte lane merge for partial writes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  // read mux, unmapped words answer zero with an error
  function automatic logic [32:0] read_word(input state_s st, input logic [thermo_pkg::ADDR_W-1:0] a,
                                            input logic alt_on);
    logic [32:0] r;
    r = {1'b0, 32'h0000_0000};
    unique case (a)
      thermo_pkg::OFS_CTRL: r[thermo_pkg::CTRL_W-1:0] = st.ctrl;
      thermo_pkg::OFS_TEMP: r[TW-1:0] = st.temp;
      thermo_pkg::OFS_BAND: r[31:0] = {st.cband, st.hband};
      thermo_pkg::OFS_CVAR: r[thermo_pkg::CVAR_W-1:0] = st.cvar;
      thermo_pkg::OFS_PERIOD: r[31:0] = st.period;
      thermo_pkg::OFS_STATUS: begin
        r[thermo_pkg::STAT_CMD] = st.cmd;
        r[thermo_pkg::STAT_RUN] = st.running;
        r[thermo_pkg::STAT_ALT] = alt_on;
      end
      thermo_pkg::OFS_SENDS: r[15:0] = st.sends;
      default: begin
        if (a >= thermo_pkg::OFS_SETPT && a[1:0] == 2'h0 && int'(a) < SETPT_END) begin
          r[TW-1:0] = st.setpt[a[4:2]];
        end else begin
          r[32] = 1'b1;
        end
      end
    endcase
    return r;
  endfunction : read_word

  // ----------------------------------------------------------------
  // decoded configuration
  // ----------------------------------------------------------------
  assign en = s.ctrl[thermo_pkg::CTRL_EN];
  assign pwm = s.ctrl[thermo_pkg::CTRL_PWM];
  assign cool = s.ctrl[thermo_pkg::CTRL_COOL];
  // radiant panels unlock the swapped band placement, otherwise default sides
  assign alt_eff = s.ctrl[thermo_pkg::CTRL_ALT] && s.ctrl[thermo_pkg::CTRL_RADIANT];
  assign idx = {cool, s.ctrl[thermo_pkg::CTRL_MODE +: 2]};
  assign sp = s.setpt[idx];

  // season decision; each season has its own band
  hyst_decide #(
    .W(TW)
  ) u_hyst (
    .temp(s.temp),
    .setpt(sp),
    .band(cool ? s.cband : s.hband),
    .cool(cool),
    .alt(alt_eff),
    .cur(s.cmd),
    .nxt(hyst_nxt)
  );

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  // one write at a time: channels close until the response is taken
  assign awready = !s.aw_got && !s.bvalid;
  assign wready = !s.w_got && !s.bvalid;
  assign arready = !s.rvalid;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign cmd = s.cmd;
  assign cmd_send = s.send;
  assign pwm_running = s.running;
  assign wr_fire = s.aw_got && s.w_got && !s.bvalid;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    merged = merge_bytes(32'h0000_0000, s.w_data, s.w_strb);
    prod = 40'(s.period) * 40'(s.cvar);
    sp_chg = 1'b0;
    // address and data are accepted in either order
    if (awvalid && awready) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.w_got = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    // register writes once both halves are held
    if (wr_fire) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = thermo_pkg::RESP_OKAY;
      unique case (s.aw_addr)
        thermo_pkg::OFS_CTRL: begin
          merged = merge_bytes({25'h0000000, s.ctrl}, s.w_data, s.w_strb);
          next_s.ctrl = merged[thermo_pkg::CTRL_W-1:0];
        end
        thermo_pkg::OFS_TEMP: begin
          merged = merge_bytes({16'h0000, s.temp}, s.w_data, s.w_strb);
          next_s.temp = merged[TW-1:0];
        end
        thermo_pkg::OFS_BAND: begin
          merged = merge_bytes({s.cband, s.hband}, s.w_data, s.w_strb);
          next_s.hband = merged[TW-1:0];
          next_s.cband = merged[thermo_pkg::BAND_COOL +: TW];
        end
        thermo_pkg::OFS_CVAR: begin
          merged = merge_bytes({24'h000000, s.cvar}, s.w_data, s.w_strb);
          next_s.cvar = merged[thermo_pkg::CVAR_W-1:0];
        end
        thermo_pkg::OFS_PERIOD: begin
          merged = merge_bytes(s.period, s.w_data, s.w_strb);
          next_s.period = merged;
        end
        thermo_pkg::OFS_STATUS, thermo_pkg::OFS_SENDS: begin
          next_s.bresp = thermo_pkg::RESP_SLVERR;
        end
        default: begin
          if (s.aw_addr >= thermo_pkg::OFS_SETPT && s.aw_addr[1:0] == 2'h0 && int'(s.aw_addr) < SETPT_END) begin
            merged = merge_bytes({16'h0000, s.setpt[s.aw_addr[4:2]]}, s.w_data, s.w_strb);
            next_s.setpt[s.aw_addr[4:2]] = merged[TW-1:0];
            // only a new value on the slot in use counts as a change
            sp_chg = (s.aw_addr[4:2] == idx) && (merged[TW-1:0] != sp);
          end else begin
            next_s.bresp = thermo_pkg::RESP_SLVERR;
          end
        end
      endcase
    end
    // reads answer one cycle after the address is taken
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_s.rvalid = 1'b1;
      {next_s.rresp[1], next_s.rdata} = read_word(s, araddr, alt_eff);
      next_s.rresp[0] = 1'b0;
    end
    // a switch of mode or season selects another setpoint, also a change
    next_s.act_idx = idx;
    if (idx != s.act_idx) begin
      sp_chg = 1'b1;
    end
    // pwm cycle: restart on wrap, on entry and on a setpoint change
    wrap = (s.cnt + 32'h0000_0001) >= s.period;
    next_s.running = en && pwm;
    if (!(en && pwm)) begin
      next_s.cnt = 32'h0000_0000;
    end else if (!s.running || sp_chg || wrap) begin
      next_s.cnt = 32'h0000_0000;
      next_s.on_len = prod[39:8];
    end else begin
      next_s.cnt = s.cnt + 32'h0000_0001;
    end
    // command: off when disabled, duty in pwm, hysteresis otherwise
    if (!en) begin
      next_s.cmd = 1'b0;
    end else if (pwm) begin
      next_s.cmd = s.running && (s.cnt < s.on_len);
    end else begin
      next_s.cmd = hyst_nxt;
    end
    // each change of the command is sent once
    next_s.send = next_s.cmd != s.cmd;
    if (next_s.send) begin
      next_s.sends = s.sends + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.ctrl <= thermo_pkg::CTRL_RESET;
      s.temp <= thermo_pkg::TEMP_RESET;
      s.hband <= thermo_pkg::HBAND_RESET;
      s.cband <= thermo_pkg::CBAND_RESET;
      s.cvar <= thermo_pkg::CVAR_RESET;
      s.period <= thermo_pkg::PERIOD_RESET;
      for (int i = 0; i < thermo_pkg::SETPT_N; i++) begin
        s.setpt[i] <= (i >= thermo_pkg::SETPT_N / 2) ? thermo_pkg::SETPT_COOL_RESET
                                                     : thermo_pkg::SETPT_HEAT_RESET;
      end
      // command off and no cycle running after reset
      s.cmd <= 1'b0;
      s.running <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // widened operands so the thresholds cannot wrap
  logic signed [TW:0] t17;
  logic signed [TW:0] sp17;
  logic hyst_sel;
  logic signed [TW:0] hb17;
  logic signed [TW:0] cb17;
  assign t17 = {s.temp[TW-1], s.temp};
  assign sp17 = {sp[TW-1], sp};
  assign hyst_sel = en && !pwm;
  // bands as signed operands, so a negative temperature compares as signed
  assign hb17 = {1'b0, s.hband};
  assign cb17 = {1'b0, s.cband};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_heat_on_low: assert property (hyst_sel && !cool && !alt_eff && t17 < sp17 - hb17 |=> cmd)
    else $error("heating not switched on below lower threshold");
  a_heat_off_set: assert property (hyst_sel && !cool && !alt_eff && t17 >= sp17 |=> !cmd)
    else $error("heating not switched off at setpoint");
  a_cool_on_high: assert property (hyst_sel && cool && !alt_eff && t17 > sp17 + cb17 |=> cmd)
    else $error("cooling not switched on above upper threshold");
  a_cool_off_below: assert property (hyst_sel && cool && !alt_eff && t17 < sp17 |=> !cmd)
    else $error("cooling not switched off below setpoint");
  a_alt_heat_band: assert property (hyst_sel && !cool && alt_eff && t17 >= sp17 + hb17 |=> !cmd)
    else $error("alternate heating not off at upper threshold");
  a_alt_cool_band: assert property (hyst_sel && cool && alt_eff && t17 <= sp17 - cb17 |=> !cmd)
    else $error("alternate cooling not off at lower threshold");
  a_no_alt_plain: assert property (hyst_sel && !cool && !s.ctrl[thermo_pkg::CTRL_RADIANT] && !cmd
                                   && t17 < sp17 && t17 >= sp17 - hb17 |=> !cmd)
    else $error("alternate placement used without radiant emitter");
  a_hold_between: assert property (hyst_sel && !cool && !alt_eff && t17 < sp17
                                   && t17 >= sp17 - hb17 |=> $stable(cmd))
    else $error("command changed between thresholds");
  a_send_change: assert property ($changed(cmd) |-> cmd_send ##1 !cmd_send || $changed(cmd))
    else $error("command change not sent");
  a_pwm_duty: assert property (en && pwm && s.running |=> cmd == $past(s.cnt < s.on_len))
    else $error("pwm output does not follow on time");
  a_pwm_restart: assert property (en && pwm && s.running && sp_chg |=> s.cnt == 32'h0000_0000 && s.running)
    else $error("setpoint change did not restart the cycle");

  c_heat_cycle: cover property (hyst_sel && !cool && $rose(cmd) ##[1:1000] $fell(cmd));
  c_alt_cool: cover property (hyst_sel && cool && alt_eff && $rose(cmd));
  c_pwm_restart: cover property (en && pwm && s.running && sp_chg);

endmodule : thermo_ctrl

/* thermo_pkg.sv */
// register map, field positions and reset values of the room thermostat
// assumes an AXI4-Lite master with 32-bit data and word aligned addresses
package thermo_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int TEMP_W = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TEMP = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_BAND = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CVAR = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SENDS = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_SETPT = 8'h20; // eight words, index {cool, mode}
  localparam int SETPT_N = 8;

  // ----------------------------------------------------------------
  // control word fields
  // ----------------------------------------------------------------
  localparam int CTRL_W = 7;
  localparam int CTRL_EN = 0;
  localparam int CTRL_PWM = 1;
  localparam int CTRL_COOL = 2;
  localparam int CTRL_ALT = 3;
  localparam int CTRL_MODE = 4; // two bits: comfort, stand-by, economy, protection
  localparam int CTRL_RADIANT = 6;
  localparam int BAND_COOL = 16; // cooling band in the upper half of the band word
  localparam int CVAR_W = 8;
  localparam int STAT_CMD = 0;
  localparam int STAT_RUN = 1;
  localparam int STAT_ALT = 2;

  // ----------------------------------------------------------------
  // reset values (temperatures in tenths of a degree Celsius)
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
  localparam logic [TEMP_W-1:0] TEMP_RESET = 16'h00C8;
  localparam logic [TEMP_W-1:0] HBAND_RESET = 16'h0005;
  localparam logic [TEMP_W-1:0] CBAND_RESET = 16'h0005;
  localparam logic [TEMP_W-1:0] SETPT_HEAT_RESET = 16'h00D2;
  localparam logic [TEMP_W-1:0] SETPT_COOL_RESET = 16'h0104;
  localparam logic [CVAR_W-1:0] CVAR_RESET = 8'h00;
  localparam logic [31:0] PERIOD_RESET = 32'h0000_1000;

endpackage : thermo_pkg
